// ==== shared/rsq_pkg.sv ====
// constants, field positions and types shared by the reset sequencer
package rsq_pkg;

   // ----------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------
   localparam int CLK_MHZ = 25;             // cpu clock rate in MHz
   localparam int RST_MIN_US = 250;         // least hardware reset width, us
   localparam int RST_MIN_CYC = RST_MIN_US * CLK_MHZ;  // whole us, no rounding
   localparam int GEN_MIN_CYC = 2;          // general group valid, earliest
   localparam int GEN_MAX_CYC = 8;          // general group valid, latest
   localparam int GEN_VALID_CYC = 4;        // chosen point inside the window
   localparam int EE_MAX_CYC = 11;          // eeprom pins valid, latest
   localparam int EE_VALID_CYC = 6;         // chosen point below the limit
   localparam int MEM_MAX_E = 20;           // memory group, memory-clock part
   localparam int MEM_VALID_E = 16;         // memory edges before valid
   localparam int WARM_CYC = 16;            // length of a warm reset pulse

   // ----------------------------------------------------------
   // widths
   // ----------------------------------------------------------
   localparam int CNT_W = 16;               // reset width counter
   localparam int REL_W = 4;                // cycles since release
   localparam int E_W = 5;                  // memory edges since release
   localparam int IRQ_N = 4;                // external interrupt lines
   localparam int ADDR_W = 4;               // avalon byte address bits

   // ----------------------------------------------------------
   // synchroniser bit positions
   // ----------------------------------------------------------
   localparam int SY_HWRST_N = 0;
   localparam int SY_HBRST = 1;
   localparam int SY_EMU = 2;
   localparam int SY_HOST_EN = 3;
   localparam int SY_SP2 = 4;
   localparam int SY_NMI_N = 5;
   localparam int SY_IRQ0 = 6;
   localparam int SY_MEMCLK = 10;
   localparam int SY_ADDR0 = 11;
   localparam int SY_BORD = 15;
   localparam int SY_EEAI = 16;
   localparam int SY_HD5 = 17;
   localparam int SYNC_W = 18;
   // idle-high interrupt pins start high to avoid a false edge
   localparam logic [SYNC_W-1:0] SYNC_RST = 18'h003e0;

   // ----------------------------------------------------------
   // register map
   // ----------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h4;
   localparam int ST_CORE_RST = 0;
   localparam int ST_GEN_VALID = 1;
   localparam int ST_MEM_VALID = 2;
   localparam int ST_SHORT = 3;
   localparam int ST_BORD = 4;
   localparam int ST_EEAI = 5;
   localparam int ST_HD5 = 6;
   localparam int ST_HOST_EN = 7;
   localparam int ST_ADDR0 = 8;
   localparam int ST_WARM = 12;
   localparam int CT_RESTART = 0;
   localparam int CT_CLR_SHORT = 1;

   // sequencer states
   typedef enum logic [1:0] {
      ST_HW,
      ST_WARMING,
      ST_RUN
   } rsq_state_t;

endpackage

// ==== shared/rsq_sync_if.sv ====
// raw pin levels and their synchronised copies
`timescale 1ns/1ps
interface rsq_sync_if;
   logic [rsq_pkg::SYNC_W-1:0] raw;   // pin levels, asynchronous
   logic [rsq_pkg::SYNC_W-1:0] sync;  // after two flip-flops
   modport user (output raw, input sync);
   modport syncer (input raw, output sync);
endinterface

// ==== src/rsq_pin_sync.sv ====
// two-stage synchroniser for every asynchronous pin of the sequencer
`timescale 1ns/1ps
module rsq_pin_sync (
   input wire logic clk_in,
   input wire logic rst_in,
   rsq_sync_if.syncer pins
);

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   logic [rsq_pkg::SYNC_W-1:0] meta;  // first stage, read by stage two only
   logic [rsq_pkg::SYNC_W-1:0] stable; // second stage
   logic [rsq_pkg::SYNC_W-1:0] next_meta;
   logic [rsq_pkg::SYNC_W-1:0] next_stable;

   // next values: plain shift
   always_comb begin
      next_meta = pins.raw;
      next_stable = meta;
   end

   // registers, reset to the idle pin levels
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta <= rsq_pkg::SYNC_RST;
         stable <= rsq_pkg::SYNC_RST;
      end else begin
         meta <= next_meta;
         stable <= next_stable;
      end
   end

   assign pins.sync = stable;

endmodule // rsq_pin_sync

// ==== src/rsq_top.sv ====
// reset sequencer: reset release, strap latch, pin groups, irq edges
`timescale 1ns/1ps

module rsq_top #(
   parameter int RST_MIN_CYC = rsq_pkg::RST_MIN_CYC,  // shorten in simulation
   parameter int WARM_CYC = rsq_pkg::WARM_CYC
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic board_reset_n_in,
   input wire logic emu_reset_in,
   input wire logic host_bus_reset_in,
   input wire logic host_bus_enable_in,
   input wire logic serial_port2_select_in,
   input wire logic memory_if_clock_in,
   input wire logic nmi_n_in,
   input wire logic [rsq_pkg::IRQ_N-1:0] external_irq_line_n_in,
   input wire logic [3:0] boot_addr_strap_in,
   input wire logic byte_order_strap_in,
   input wire logic eeprom_autoinit_strap_in,
   input wire logic host_data5_strap_in,
   input wire logic [rsq_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic core_reset_out,
   output logic host_if_reset_out,
   output logic mem_group_float_out,
   output logic gen_group_float_out,
   output logic eeprom_drive_low_out,
   output logic eeprom_float_out,
   output logic [3:0] boot_addr_out,
   output logic byte_order_out,
   output logic eeprom_autoinit_out,
   output logic host_data5_out,
   output logic short_reset_out,
   output logic nmi_event_out,
   output logic [rsq_pkg::IRQ_N-1:0] ext_irq_event_out
);

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   // address match, shared by read mux and write decode
   function automatic logic hit(input logic [rsq_pkg::ADDR_W-1:0] a,
                                input logic [rsq_pkg::ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // ----------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------
   rsq_sync_if pins ();  // raw and synced pin vector

   // every asynchronous pin enters here
   assign pins.raw = {host_data5_strap_in, eeprom_autoinit_strap_in,
                      byte_order_strap_in, boot_addr_strap_in,
                      memory_if_clock_in, external_irq_line_n_in,
                      nmi_n_in, serial_port2_select_in,
                      host_bus_enable_in, emu_reset_in,
                      host_bus_reset_in, board_reset_n_in};

   rsq_pin_sync u_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .pins(pins)
   );

   logic [rsq_pkg::SYNC_W-1:0] sy;  // synced copy, the only one read
   assign sy = pins.sync;

   logic hw_n;      // board reset, low while asserted
   logic host_en;   // host bus enable strap
   logic sp2_sel;   // serial port 2 selected
   assign hw_n = sy[rsq_pkg::SY_HWRST_N];
   assign host_en = sy[rsq_pkg::SY_HOST_EN];
   assign sp2_sel = sy[rsq_pkg::SY_SP2];

   // ----------------------------------------------------------
   // bus slave state
   // ----------------------------------------------------------
   logic ack;                  // one-cycle answer phase
   logic next_ack;
   logic [31:0] rdata;         // registered read data
   logic [31:0] next_rdata;
   logic req;                  // a request is on the bus
   logic wr_take;              // write takes effect this edge
   logic restart_wr;           // software warm reset strobe
   logic clr_short_wr;         // software clear of short flag

   assign req = avs_read_in | avs_write_in;
   // one wait cycle, then waitrequest drops for the answer edge
   assign avs_waitrequest_out = req & ~ack;
   assign avs_readdata_out = rdata;
   assign wr_take = avs_write_in & ack &
                    hit(avs_address_in, rsq_pkg::REG_CTRL) &
                    avs_byteenable_in[0];
   assign restart_wr = wr_take & avs_writedata_in[rsq_pkg::CT_RESTART];
   assign clr_short_wr = wr_take & avs_writedata_in[rsq_pkg::CT_CLR_SHORT];

   // ----------------------------------------------------------
   // sequencer state
   // ----------------------------------------------------------
   rsq_pkg::rsq_state_t state;        // current reset phase
   rsq_pkg::rsq_state_t next_state;
   logic [rsq_pkg::CNT_W-1:0] low_cnt;   // cycles reset held low
   logic [rsq_pkg::CNT_W-1:0] next_low_cnt;
   logic [rsq_pkg::CNT_W-1:0] warm_cnt;  // cycles into a warm reset
   logic [rsq_pkg::CNT_W-1:0] next_warm_cnt;
   logic [rsq_pkg::REL_W-1:0] rel_cnt;   // cpu cycles since release
   logic [rsq_pkg::REL_W-1:0] next_rel_cnt;
   logic [rsq_pkg::E_W-1:0] e_cnt;       // memory edges since release
   logic [rsq_pkg::E_W-1:0] next_e_cnt;
   logic e_prev;                         // last synced memory clock
   logic [3:0] boot_addr;                // latched straps
   logic [3:0] next_boot_addr;
   logic bord;
   logic next_bord;
   logic eeai;
   logic next_eeai;
   logic hd5;
   logic next_hd5;
   logic short_flag;                     // a reset pulse was too short, held until cleared
   logic next_short;
   logic warm_cause;                     // last reset was a warm one
   logic next_warm_cause;
   logic gen_valid;                      // general group driven
   logic next_gen_valid;
   logic mem_valid;                      // memory group driven
   logic next_mem_valid;
   logic ee_valid;                       // eeprom pins released
   logic next_ee_valid;
   logic emu_prev;                       // emulation request edge
   logic warm_req;                       // accepted warm request
   logic e_rise;                         // memory clock rising edge

   assign e_rise = sy[rsq_pkg::SY_MEMCLK] & ~e_prev;
   // host request only while host bus enabled
   // emulation request enters the same path
   assign warm_req = (restart_wr & host_en) |
                     (sy[rsq_pkg::SY_EMU] & ~emu_prev);

   // next values of the sequencer and the bus answer
   always_comb begin
      next_state = state;
      next_low_cnt = low_cnt;
      next_warm_cnt = warm_cnt;
      next_rel_cnt = rel_cnt;
      next_e_cnt = e_cnt;
      next_boot_addr = boot_addr;
      next_bord = bord;
      next_eeai = eeai;
      next_hd5 = hd5;
      next_short = short_flag;
      next_warm_cause = warm_cause;
      next_ack = req & ~ack;
      next_rdata = rdata;
      // clear first, so a set below wins in the same cycle
      if (clr_short_wr) begin
         next_short = 1'b0;
      end
      case (state)
         rsq_pkg::ST_HW: begin
            // measure the width, saturating at the least width
            if (low_cnt < RST_MIN_CYC[rsq_pkg::CNT_W-1:0]) begin
               next_low_cnt = low_cnt + 1'b1;
            end
            if (hw_n) begin
               // catch the straps on the release edge
               next_boot_addr = sy[rsq_pkg::SY_ADDR0 +: 4];
               next_bord = sy[rsq_pkg::SY_BORD];
               next_eeai = sy[rsq_pkg::SY_EEAI];
               next_hd5 = sy[rsq_pkg::SY_HD5];
               next_warm_cause = 1'b0;
               // pulse shorter than the least width is flagged
               if (low_cnt < RST_MIN_CYC[rsq_pkg::CNT_W-1:0]) begin
                  next_short = 1'b1;
               end
               next_rel_cnt = '0;
               next_e_cnt = '0;
               next_state = rsq_pkg::ST_RUN;
            end
         end
         rsq_pkg::ST_WARMING: begin
            // straps are not touched here
            if (!hw_n) begin
               next_low_cnt = '0;
               next_state = rsq_pkg::ST_HW;
            end else if (warm_cnt >= WARM_CYC[rsq_pkg::CNT_W-1:0]) begin
               next_rel_cnt = '0;
               next_e_cnt = '0;
               next_state = rsq_pkg::ST_RUN;
            end else begin
               next_warm_cnt = warm_cnt + 1'b1;
            end
         end
         rsq_pkg::ST_RUN: begin
            // release timers, saturating
            if (rel_cnt != '1) begin
               next_rel_cnt = rel_cnt + 1'b1;
            end
            if (e_rise && e_cnt != '1) begin
               next_e_cnt = e_cnt + 1'b1;
            end
            if (!hw_n) begin
               next_low_cnt = '0;
               next_state = rsq_pkg::ST_HW;
            end else if (warm_req) begin
               // same release path as a hardware reset
               next_warm_cnt = '0;
               next_warm_cause = 1'b1;
               next_state = rsq_pkg::ST_WARMING;
            end
         end
         default: begin
            next_state = rsq_pkg::ST_HW;
         end
      endcase
      // read answer, unmapped reads return zero
      if (req && !ack) begin
         if (hit(avs_address_in, rsq_pkg::REG_STATUS)) begin
            next_rdata = '0;
            next_rdata[rsq_pkg::ST_CORE_RST] = core_reset_out;
            next_rdata[rsq_pkg::ST_GEN_VALID] = gen_valid;
            next_rdata[rsq_pkg::ST_MEM_VALID] = mem_valid;
            next_rdata[rsq_pkg::ST_SHORT] = short_flag;
            next_rdata[rsq_pkg::ST_BORD] = bord;
            next_rdata[rsq_pkg::ST_EEAI] = eeai;
            next_rdata[rsq_pkg::ST_HD5] = hd5;
            next_rdata[rsq_pkg::ST_HOST_EN] = host_en;
            next_rdata[rsq_pkg::ST_ADDR0 +: 4] = boot_addr;
            next_rdata[rsq_pkg::ST_WARM] = warm_cause;
         end else begin
            next_rdata = '0;
         end
      end
   end

   // pin group timing, taken from the release timers
   always_comb begin
      next_gen_valid = 1'b0;
      next_mem_valid = 1'b0;
      next_ee_valid = 1'b0;
      if (next_state == rsq_pkg::ST_RUN && state == rsq_pkg::ST_RUN) begin
         // drive valid inside the 2..8 cycle window
         next_gen_valid = gen_valid |
            (rel_cnt >= rsq_pkg::GEN_VALID_CYC[rsq_pkg::REL_W-1:0]);
         // memory group after a count of memory edges
         next_mem_valid = mem_valid |
            (e_cnt >= rsq_pkg::MEM_VALID_E[rsq_pkg::E_W-1:0]);
         // eeprom pins well before the 11 cycle limit
         next_ee_valid = ee_valid |
            (rel_cnt >= rsq_pkg::EE_VALID_CYC[rsq_pkg::REL_W-1:0]);
      end
   end

   // registers; only the power-on reset clears them, never host bus reset
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= rsq_pkg::ST_HW;
         low_cnt <= '0;
         warm_cnt <= '0;
         rel_cnt <= '0;
         e_cnt <= '0;
         e_prev <= 1'b0;
         emu_prev <= 1'b0;
         boot_addr <= '0;
         bord <= 1'b0;
         eeai <= 1'b0;
         hd5 <= 1'b0;
         short_flag <= 1'b0;
         warm_cause <= 1'b0;
         gen_valid <= 1'b0;
         mem_valid <= 1'b0;
         ee_valid <= 1'b0;
         ack <= 1'b0;
         rdata <= '0;
      end else begin
         state <= next_state;
         low_cnt <= next_low_cnt;
         warm_cnt <= next_warm_cnt;
         rel_cnt <= next_rel_cnt;
         e_cnt <= next_e_cnt;
         e_prev <= sy[rsq_pkg::SY_MEMCLK];
         emu_prev <= sy[rsq_pkg::SY_EMU];
         boot_addr <= next_boot_addr;
         bord <= next_bord;
         eeai <= next_eeai;
         hd5 <= next_hd5;
         short_flag <= next_short;
         warm_cause <= next_warm_cause;
         gen_valid <= next_gen_valid;
         mem_valid <= next_mem_valid;
         ee_valid <= next_ee_valid;
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------
   // reset and pin group outputs
   // ----------------------------------------------------------
   // core reset covers hardware and warm phases alike
   assign core_reset_out = (state != rsq_pkg::ST_RUN);
   // host interface reset follows its own pin only
   assign host_if_reset_out = sy[rsq_pkg::SY_HBRST];
   // valid flags drop the cycle the phase leaves run
   assign gen_group_float_out = ~gen_valid;
   assign mem_group_float_out = ~mem_valid;
   // eeprom pins held low only with host bus on, port 2 off
   assign eeprom_drive_low_out = host_en & ~sp2_sel & ~ee_valid;
   assign eeprom_float_out = ~(host_en & ~sp2_sel) & ~gen_valid;
   assign boot_addr_out = boot_addr;
   assign byte_order_out = bord;
   assign eeprom_autoinit_out = eeai;
   assign host_data5_out = hd5;
   assign short_reset_out = short_flag;

   // ----------------------------------------------------------
   // interrupt edge detect
   // ----------------------------------------------------------
   // pins idle high; a falling edge of the synced level is an event.
   // pulses narrower than the sync window may be missed
   logic nmi_prev;
   logic [rsq_pkg::IRQ_N-1:0] irq_prev;
   logic next_nmi_ev;
   logic [rsq_pkg::IRQ_N-1:0] next_irq_ev;
   logic [rsq_pkg::IRQ_N-1:0] irq_now;

   assign irq_now = sy[rsq_pkg::SY_IRQ0 +: rsq_pkg::IRQ_N];

   // next event pulses from the synced levels
   always_comb begin
      next_nmi_ev = nmi_prev & ~sy[rsq_pkg::SY_NMI_N];
      next_irq_ev = irq_prev & ~irq_now;
   end

   // edge registers, idle high after reset
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         nmi_prev <= 1'b1;
         irq_prev <= '1;
         nmi_event_out <= 1'b0;
         ext_irq_event_out <= '0;
      end else begin
         nmi_prev <= sy[rsq_pkg::SY_NMI_N];
         irq_prev <= irq_now;
         nmi_event_out <= next_nmi_ev;
         ext_irq_event_out <= next_irq_ev;
      end
   end

endmodule // rsq_top

// ==== testbench/rsq_chk.sv ====
// port assertions for the reset sequencer
`timescale 1ns/1ps
module rsq_chk (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic host_bus_reset_in,
   input wire logic emu_reset_in,
   input wire logic core_reset_out,
   input wire logic host_if_reset_out,
   input wire logic mem_group_float_out,
   input wire logic gen_group_float_out,
   input wire logic eeprom_drive_low_out,
   input wire logic [3:0] boot_addr_out,
   input wire logic nmi_event_out
);
   // -----------------------------------------
   // checks
   // -----------------------------------------
   // assumes the memory clock runs at a quarter of the cpu clock
   localparam int MEM_MAX = 88;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   a_core_float: assert property (core_reset_out |=> gen_group_float_out)
      else $error("general group driven during reset");
   a_mem_float: assert property ($rose(core_reset_out) |-> ##[0:3] mem_group_float_out)
      else $error("memory group not floated");
   a_gen_window: assert property ($fell(core_reset_out) |->
      gen_group_float_out [*2] ##[0:7] !gen_group_float_out)
      else $error("general group valid outside its window");
   a_mem_valid: assert property ($fell(core_reset_out) |-> ##[1:MEM_MAX] !mem_group_float_out)
      else $error("memory group valid too late");
   a_ee_valid: assert property ($fell(core_reset_out) && eeprom_drive_low_out |->
      ##[1:11] !eeprom_drive_low_out)
      else $error("eeprom pins released too late");
   a_host_follow: assert property (host_if_reset_out == $past(host_bus_reset_in, 2))
      else $error("host interface reset does not follow its pin");
   a_core_keep: assert property ($rose(host_bus_reset_in) && !core_reset_out |=>
      !core_reset_out [*4])
      else $error("host bus reset disturbed the core");
   a_strap_hold: assert property (!core_reset_out && $past(!core_reset_out) |->
      $stable(boot_addr_out))
      else $error("latched straps changed while running");
   a_emu_acts: assert property ($rose(emu_reset_in) && !core_reset_out |-> ##[1:8] core_reset_out)
      else $error("emulation reset not taken");
   a_nmi_once: assert property (nmi_event_out |=> !nmi_event_out)
      else $error("nmi event longer than one cycle");
   c_gen_valid: cover property ($fell(gen_group_float_out));
   c_nmi: cover property (nmi_event_out);
   c_host_rst: cover property ($rose(host_if_reset_out));
endmodule // rsq_chk

bind rsq_top rsq_chk chk_u (.clk_in(clk_in), .rst_in(rst_in),
   .host_bus_reset_in(host_bus_reset_in), .emu_reset_in(emu_reset_in),
   .core_reset_out(core_reset_out), .host_if_reset_out(host_if_reset_out),
   .mem_group_float_out(mem_group_float_out), .gen_group_float_out(gen_group_float_out),
   .eeprom_drive_low_out(eeprom_drive_low_out), .boot_addr_out(boot_addr_out),
   .nmi_event_out(nmi_event_out));

// ==== testbench/rsq_board_model.sv ====
// board side: hardware reset pulses and the memory clock
`timescale 1ns/1ps
module rsq_board_model #(
   parameter int LONG_CYC = 24,  // full-width reset pulse
   parameter int SHORT_CYC = 10  // deliberately too short
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic go_in,     // start a reset pulse
   input wire logic short_in,  // make that pulse too short
   output logic board_reset_n_out,
   output logic mem_clk_out
);
   int unsigned left;  // cycles of reset still to hold
   logic [1:0] div;    // memory clock divider, keeps it below cpu / 2
   // reset counter and divider; low from power-up until the count runs out
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         left <= LONG_CYC;
         div <= 2'h0;
      end else begin
         div <= div + 2'h1;
         if (go_in) begin
            left <= short_in ? SHORT_CYC : LONG_CYC;
         end else if (left != 0) begin
            left <= left - 1;
         end
      end
   end
   assign board_reset_n_out = (left == 0);
   assign mem_clk_out = div[1];
endmodule // rsq_board_model

// ==== testbench/rsq_top_tb.sv ====
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
module rsq_top_tb;
   // -----------------------------------------
   // signals
   // -----------------------------------------
   localparam int RMIN = 20;  // shortened reset width
   typedef struct packed {
      logic n;
      logic [3:0] i;
      logic ne;
      logic [3:0] ie;
   } rsq_row_t;  // pin levels beside the events they raise
   rsq_row_t rows [4] = '{'{1'h0, 4'hf, 1'h1, 4'h0}, '{1'h1, 4'he, 1'h0, 4'h1},
      '{1'h0, 4'h7, 1'h1, 4'h8}, '{1'h1, 4'h0, 1'h0, 4'hf}};
   logic clk_in, rst_in, emu, hbr, hen, sp2, nmi_n, go, short_go, rd, wr, bo, eeai, hd5;
   logic board_rst_n, mclk, wreq, core, gen_fl, mem_fl, ee_low, ee_fl, short_fl, hif;
   logic nmi_ev, bo_q, ea_q, h5_q;
   logic [3:0] irq_n, baddr, addr, irq_ev, baddr_q;
   logic [31:0] wdata, q, rdata;
   int miscompares, n_compared, g, m;
   rsq_board_model #(.LONG_CYC(RMIN + 12), .SHORT_CYC(RMIN / 2)) board_u (.clk_in(clk_in),
      .rst_in(rst_in), .go_in(go), .short_in(short_go), .board_reset_n_out(board_rst_n),
      .mem_clk_out(mclk));
   rsq_top #(.RST_MIN_CYC(RMIN), .WARM_CYC(4)) dut_u (.clk_in(clk_in), .rst_in(rst_in),
      .board_reset_n_in(board_rst_n), .emu_reset_in(emu), .host_bus_reset_in(hbr),
      .host_bus_enable_in(hen), .serial_port2_select_in(sp2), .memory_if_clock_in(mclk),
      .nmi_n_in(nmi_n), .external_irq_line_n_in(irq_n), .boot_addr_strap_in(baddr),
      .byte_order_strap_in(bo), .eeprom_autoinit_strap_in(eeai), .host_data5_strap_in(hd5),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
      .core_reset_out(core), .host_if_reset_out(hif), .mem_group_float_out(mem_fl),
      .gen_group_float_out(gen_fl), .eeprom_drive_low_out(ee_low), .eeprom_float_out(ee_fl),
      .boot_addr_out(baddr_q), .byte_order_out(bo_q), .eeprom_autoinit_out(ea_q),
      .host_data5_out(h5_q), .short_reset_out(short_fl), .nmi_event_out(nmi_ev),
      .ext_irq_event_out(irq_ev));
   // -----------------------------------------
   // tasks
   // -----------------------------------------
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      rd <= ~w;
      wr <= w;
      do begin
         @(negedge clk_in);
         n++;
      end while (wreq !== 1'h0);
      @(posedge clk_in);
      q = rdata;
      rd <= 1'h0;
      wr <= 1'h0;
      chk("bus wait states", 2, n);
   endtask
   // time one reset and the pin groups after it
   task automatic rel();
      int n = 0;
      while (core !== 1'h1 && n < 20) begin
         @(negedge clk_in);
         n++;
      end
      chk("core in reset", 1, core);
      while (core !== 1'h0 && n < 200) begin
         @(negedge clk_in);
         n++;
      end
      g = 0;
      m = 0;
      while (mem_fl !== 1'h0 && m < 200) begin
         @(negedge clk_in);
         m++;
         g += (gen_fl !== 1'h0);
      end
      chk("gen window", 1, g >= 1 && g <= 7);
      chk("mem valid", 1, m <= 88);
   endtask
   // power-on reset with a new host bus enable level
   task automatic por(input logic h);
      @(posedge clk_in);
      rst_in <= 1'h1;
      hen <= h;
      tick(2);
      @(posedge clk_in);
      rst_in <= 1'h0;
      tick(3);  // let the synced strap levels settle
   endtask
   task automatic print_verdict();
      if (miscompares == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // -----------------------------------------
   // stimulus
   // -----------------------------------------
   initial begin
      clk_in = 1'h0;
      forever #20 clk_in = ~clk_in;  // runs long before any release
   end
   // watchdog, well past the run's length
   initial begin
      repeat (20000) @(posedge clk_in);
      miscompares++;
      print_verdict();
   end
   initial begin
      {rst_in, emu, hbr, hen, sp2, go, short_go, rd, wr} = 9'h100;
      {nmi_n, irq_n} = 5'h1f;  // interrupt pins idle high
      {baddr, bo, eeai, hd5} = 7'h55;
      addr = 4'h0;
      wdata = 32'h0;
      miscompares = 0;
      n_compared = 0;
      tick(2);
      @(posedge clk_in);
      rst_in <= 1'h0;
      tick(1);
      chk("floats", 3'h7, {core, gen_fl, mem_fl});
      chk("host if", 0, hif);
      rel();
      bus(1'h1, 4'h4, 32'h1);
      tick(4);
      chk("refused restart", 0, core);
      por(1'h1);
      chk("ee low", 2'h2, {ee_low, ee_fl});
      rel();
      chk("straps", 7'h55, {baddr_q, bo_q, ea_q, h5_q});
      chk("short flag", 0, short_fl);
      @(posedge clk_in);
      {baddr, bo, eeai, hd5} <= 7'h2a;
      tick(5);
      chk("straps kept", 7'h55, {baddr_q, bo_q, ea_q, h5_q});
      bus(1'h0, 4'h0, 32'h0);
      chk("status", 32'h0ad6, q);
      for (int a = 4; a < 16; a += 4) begin
         bus(1'h0, 4'(a), 32'h0);
         chk("empty read", 0, q);
      end
      bus(1'h1, 4'h4, 32'h1);
      rel();
      chk("warm straps", 7'h55, {baddr_q, bo_q, ea_q, h5_q});
      bus(1'h0, 4'h0, 32'h0);
      chk("warm flag", 1, q[12]);
      @(posedge clk_in);
      emu <= 1'h1;
      rel();
      chk("emu straps", 7'h55, {baddr_q, bo_q, ea_q, h5_q});
      @(posedge clk_in);
      {emu, hbr} <= 2'h1;
      tick(4);
      chk("host reset", 2'h2, {hif, core});
      @(posedge clk_in);
      hbr <= 1'h0;
      tick(4);
      chk("host reset off", 0, hif);
      // each row: pins low 8 cycles, event after 3, then high 8
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in);
         nmi_n <= rows[i].n;
         irq_n <= rows[i].i;
         tick(4);
         chk("nmi event", 32'(rows[i].ne), 32'(nmi_ev));
         chk("irq event", 32'(rows[i].ie), 32'(irq_ev));
         tick(4);
         @(posedge clk_in);
         {nmi_n, irq_n} <= 5'h1f;
         tick(8);
      end
      @(posedge clk_in);
      {go, short_go, sp2} <= 3'h7;
      @(posedge clk_in);
      go <= 1'h0;
      tick(5);
      chk("ee float", 2'h1, {ee_low, ee_fl});
      rel();
      chk("short set", 1, short_fl);
      chk("straps relatched", 7'h2a, {baddr_q, bo_q, ea_q, h5_q});
      bus(1'h1, 4'h4, 32'h2);
      tick(1);
      chk("short cleared", 0, short_fl);
      print_verdict();
   end
endmodule // rsq_top_tb
